/* include/ppp_pkg.sv */
/*
 * shared constants of the parallel programming port: pin codes,
 * command bytes, timing figures and the host's register map.
 * assumes a 40 MHz system clock on both ends.
 */
package ppp_pkg;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_DVXH_NS = 67;
	localparam int T_XHXL_NS = 150;
	localparam int T_XLDX_NS = 67;
	localparam int T_OLDV_NS = 250;
	localparam int T_WLRL_MAX_NS = 1000;
	localparam int T_WLRH_MIN_US = 3700;
	localparam int T_WLRH_CE_MIN_US = 7500;
	localparam int SYNC_LAT = 4;
	localparam int CYC_DVXH = (T_DVXH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_XHXL = (T_XHXL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_XLDX = (T_XLDX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_RD = (T_OLDV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
		+ 2 * SYNC_LAT;
	localparam int CYC_WLRL = T_WLRL_MAX_NS / CLK_PERIOD_NS;
	localparam int CYC_WRITE = (T_WLRH_MIN_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CYC_ERASE = (T_WLRH_CE_MIN_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// ==========================================================
	// action codes and command bytes
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WFUSE = 8'h40;
	localparam logic [7:0] CMD_WLOCK = 8'h20;
	localparam logic [7:0] CMD_WFLASH = 8'h10;
	localparam logic [7:0] CMD_WEE = 8'h11;
	localparam logic [7:0] CMD_RSIG = 8'h08;
	localparam logic [7:0] CMD_RFUSE = 8'h04;
	localparam logic [7:0] CMD_RFLASH = 8'h02;
	localparam logic [7:0] CMD_REE = 8'h03;
	localparam logic [7:0] BYTE_ERASED = 8'hFF;
	// ==========================================================
	// host register map and fields
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STAT = 12'h004;
	localparam int CF_DATA = 0;
	localparam int CF_ACT = 8;
	localparam int CF_BSL = 10;
	localparam int CF_BSS = 11;
	localparam int CF_OP = 12;
	localparam int SF_BUSY = 0;
	localparam int SF_READY = 1;
	localparam int SF_RDATA = 8;
	localparam logic [1:0] OP_LOAD = 2'h0;
	localparam logic [1:0] OP_LATCH = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
endpackage : ppp_pkg

/* include/ppp_if.sv */
/*
 * pins between programmer and device.
 * assumes each end drives the data bus only with its enable low.
 */
`timescale 1ns/1ps
interface ppp_if;
	logic load_strobe;
	logic action_code_hi;
	logic action_code_lo;
	logic byte_sel_low_high;
	logic byte_sel_second;
	logic page_latch_strobe;
	logic prog_strobe_n;
	logic out_en_n;
	logic ready_flag;
	logic [7:0] data_host;
	logic data_host_oe_n;
	logic [7:0] data_dev;
	logic data_dev_oe_n;
	logic [7:0] data;

	// an undriven bus reads as all ones
	assign data = !data_dev_oe_n ? data_dev :
		(!data_host_oe_n ? data_host : 8'hFF);

	modport dev (
		input load_strobe, action_code_hi, action_code_lo,
		input byte_sel_low_high, byte_sel_second, page_latch_strobe,
		input prog_strobe_n, out_en_n, data,
		output ready_flag, data_dev, data_dev_oe_n
	);
	modport host (
		output load_strobe, action_code_hi, action_code_lo,
		output byte_sel_low_high, byte_sel_second, page_latch_strobe,
		output prog_strobe_n, out_en_n, data_host, data_host_oe_n,
		input ready_flag, data
	);
endinterface : ppp_if

/* src/ppp_sync.sv */
/*
 * three-stage pin synchroniser with agreement filter.
 * assumes inputs are asynchronous to CLK_SYS.
 */
`timescale 1ns/1ps
module ppp_sync
	import ppp_pkg::*;
#(
	parameter int W = 8
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

	// a bit moves only when stages two and three agree
	always_comb
	begin
		lvl_d = (s3_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level = lvl_q;
endmodule : ppp_sync

/* src/ppp_dev.sv */
/*
 * device end of the parallel programming port: command, address and
 * data latches, page buffer, flash/eeprom arrays, fuses and lock bits,
 * self-timed write with ready flag, and the read-back mux.
 * assumes the programmer drives the pins asynchronously to CLK_SYS.
 */
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - action code picks address, data or command load
// - ready flag low while busy, high otherwise
// - select 0 address load takes low byte
// - page latch strobe stores data at word
// - select 1 address load takes high byte
// - program strobe, select 0 writes flash page
// - programmer waits for ready before next load
// - no-operation command clears write latches
// - eeprom page write via command 0x11
// - flash read gives low or high byte
// - eeprom read drives addressed byte
// - fuse low write, selects both zero
// - fuse high write with select one
// - lock write programs zero bits only
// - only chip erase clears lock bits
// - fuse/lock read by the two selects
// - identification read by low address 0..2
// - calibration byte at address zero, select one
// - ready falls within one microsecond of strobe
// - writes busy between 3.7 and 4.5 ms
// - chip erase busy between 7.5 and 9 ms
module ppp_dev
	import ppp_pkg::*;
#(
	parameter int FLASH_AW = 8,
	parameter int PAGE_AW = 6,
	parameter int EE_AW = 10,
	parameter int EPAGE_AW = 2,
	parameter int WRITE_CYC = CYC_WRITE,
	parameter int ERASE_CYC = CYC_ERASE,
	parameter logic [7:0] FUSE_LO_RST = 8'hFF,
	parameter logic [7:0] FUSE_HI_RST = 8'hFF,
	// identification and calibration values are arbitrary
	parameter logic [7:0] ID0 = 8'h5A,
	parameter logic [7:0] ID1 = 8'hA5,
	parameter logic [7:0] ID2 = 8'h3C,
	parameter logic [7:0] CAL_BYTE = 8'h80
)(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	ppp_if.dev PINS,
	output logic [7:0] FUSE_LO,
	output logic [7:0] FUSE_HI,
	output logic [7:0] LOCK_BITS
);
	// ==========================================================
	// parameter checks
	if (PAGE_AW >= FLASH_AW || EPAGE_AW >= PAGE_AW || PAGE_AW > EE_AW
		|| FLASH_AW > 16 || EE_AW > 16)
	begin : g_bad_geom
		$error("ppp_dev: unsupported memory geometry");
	end
	if (WRITE_CYC < 1 || ERASE_CYC < 1 || ERASE_CYC >= (1 << 20)
		|| WRITE_CYC >= (1 << 20))
	begin : g_bad_time
		$error("ppp_dev: busy counts out of range");
	end

	typedef enum logic [1:0] {
		ST_READY = 2'b01,
		ST_BUSY = 2'b10
	} ppp_dstate_e;

	// ==========================================================
	// pin synchronisers and edges
	logic [15:0] sync_lvl;
	logic s_ld, s_ach, s_acl, s_bsl, s_bss, s_pl, s_wr_n, s_oe_n;
	logic [7:0] s_dat;
	logic ld_prev_q, pl_prev_q, wr_prev_q;
	logic ld_rise, pl_rise, wr_fall;

	ppp_sync #(.W(16)) u_sync (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.pin({PINS.load_strobe, PINS.action_code_hi, PINS.action_code_lo,
			PINS.byte_sel_low_high, PINS.byte_sel_second,
			PINS.page_latch_strobe, !PINS.prog_strobe_n, !PINS.out_en_n,
			PINS.data}),
		.level(sync_lvl)
	);

	// low-active pins pass inverted, so the zero reset is their idle level
	assign {s_ld, s_ach, s_acl, s_bsl, s_bss, s_pl, s_wr_n, s_oe_n} =
		{sync_lvl[15:10], ~sync_lvl[9:8]};
	assign s_dat = sync_lvl[7:0];
	assign ld_rise = s_ld && !ld_prev_q;
	assign pl_rise = s_pl && !pl_prev_q;
	assign wr_fall = !s_wr_n && wr_prev_q;

	// ==========================================================
	// memories
	logic [15:0] flash_mem [2**FLASH_AW];
	logic [7:0] ee_mem [2**EE_AW];
	logic [15:0] pbuf [2**PAGE_AW];
	logic [FLASH_AW-1:0] faddr;
	logic [EE_AW-1:0] eaddr;
	logic [15:0] fword;

	// ==========================================================
	// control state
	ppp_dstate_e state_q, state_d;
	logic [7:0] cmd_q, cmd_d, ahi_q, ahi_d, alo_q, alo_d;
	logic [7:0] dlo_q, dlo_d, dhi_q, dhi_d;
	logic [7:0] fuse_lo_q, fuse_lo_d, fuse_hi_q, fuse_hi_d;
	logic [7:0] lock_q, lock_d, dout_q, dout_d;
	logic page_ok_q, page_ok_d, doe_n_q, doe_n_d, ready_q, ready_d;
	logic [19:0] cnt_q, cnt_d;
	logic do_flash, do_ee, do_erase;

	assign faddr = FLASH_AW'({ahi_q, alo_q});
	assign eaddr = EE_AW'({ahi_q, alo_q});
	assign fword = flash_mem[faddr];

	always_comb
	begin
		state_d = state_q;
		cmd_d = cmd_q;
		ahi_d = ahi_q;
		alo_d = alo_q;
		dlo_d = dlo_q;
		dhi_d = dhi_q;
		fuse_lo_d = fuse_lo_q;
		fuse_hi_d = fuse_hi_q;
		lock_d = lock_q;
		page_ok_d = page_ok_q;
		cnt_d = cnt_q;
		do_flash = 1'b0;
		do_ee = 1'b0;
		do_erase = 1'b0;
		case (state_q)
		ST_READY:
		begin
			// loads are ignored while busy; the programmer waits
			if (ld_rise)
			begin
				case ({s_ach, s_acl})
				ACT_ADDR:
				begin
					if (s_bsl)
						ahi_d = s_dat;
					else
						alo_d = s_dat;
				end
				ACT_DATA:
				begin
					if (s_bsl)
						dhi_d = s_dat;
					else
						dlo_d = s_dat;
				end
				ACT_CMD:
				begin
					cmd_d = s_dat;
					if (s_dat == CMD_NOP)
					begin
						dlo_d = BYTE_ERASED;
						dhi_d = BYTE_ERASED;
						page_ok_d = 1'b0;
					end
				end
				default:
				begin
				end
				endcase
			end
			if (pl_rise)
				page_ok_d = 1'b1;
			if (wr_fall)
			begin
				case (cmd_q)
				CMD_WFLASH:
				begin
					if (!s_bsl)
					begin
						do_flash = page_ok_q;
						page_ok_d = 1'b0;
						state_d = ST_BUSY;
						cnt_d = 20'(WRITE_CYC);
					end
				end
				CMD_WEE:
				begin
					if (!s_bsl)
					begin
						do_ee = page_ok_q;
						page_ok_d = 1'b0;
						state_d = ST_BUSY;
						cnt_d = 20'(WRITE_CYC);
					end
				end
				CMD_WFUSE:
				begin
					if (!s_bss)
					begin
						if (s_bsl)
							fuse_hi_d = dlo_q;
						else
							fuse_lo_d = dlo_q;
						state_d = ST_BUSY;
						cnt_d = 20'(WRITE_CYC);
					end
				end
				CMD_WLOCK:
				begin
					// a one can never raise a programmed lock bit
					lock_d = lock_q & dlo_q;
					state_d = ST_BUSY;
					cnt_d = 20'(WRITE_CYC);
				end
				CMD_ERASE:
				begin
					do_erase = 1'b1;
					lock_d = BYTE_ERASED;
					state_d = ST_BUSY;
					cnt_d = 20'(ERASE_CYC);
				end
				default:
				begin
				end
				endcase
			end
		end
		ST_BUSY:
		begin
			cnt_d = cnt_q - 20'h00001;
			if (cnt_q == 20'h00001)
				state_d = ST_READY;
		end
		default:
			state_d = ST_READY;
		endcase
		// flag follows the next state so it drops on the start edge
		ready_d = (state_d == ST_READY);
	end

	// ==========================================================
	// read-back mux
	always_comb
	begin
		dout_d = BYTE_ERASED;
		doe_n_d = s_oe_n;
		case (cmd_q)
		CMD_RFLASH:
			dout_d = s_bsl ? fword[15:8] : fword[7:0];
		CMD_REE:
		begin
			if (!s_bsl)
				dout_d = ee_mem[eaddr];
		end
		CMD_RFUSE:
		begin
			case ({s_bss, s_bsl})
			2'b00: dout_d = fuse_lo_q;
			2'b11: dout_d = fuse_hi_q;
			2'b01: dout_d = lock_q;
			default: dout_d = BYTE_ERASED;
			endcase
		end
		CMD_RSIG:
		begin
			if (s_bsl)
				dout_d = (alo_q == 8'h00) ? CAL_BYTE : BYTE_ERASED;
			else if (alo_q == 8'h00)
				dout_d = ID0;
			else if (alo_q == 8'h01)
				dout_d = ID1;
			else if (alo_q == 8'h02)
				dout_d = ID2;
		end
		default:
		begin
		end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_q <= ST_READY;
			cmd_q <= CMD_NOP;
			ahi_q <= 8'h00;
			alo_q <= 8'h00;
			dlo_q <= BYTE_ERASED;
			dhi_q <= BYTE_ERASED;
			fuse_lo_q <= FUSE_LO_RST;
			fuse_hi_q <= FUSE_HI_RST;
			lock_q <= BYTE_ERASED;
			page_ok_q <= 1'b0;
			cnt_q <= 20'h00000;
			ready_q <= 1'b1;
			dout_q <= BYTE_ERASED;
			doe_n_q <= 1'b1;
			ld_prev_q <= 1'b0;
			pl_prev_q <= 1'b0;
			wr_prev_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			ahi_q <= ahi_d;
			alo_q <= alo_d;
			dlo_q <= dlo_d;
			dhi_q <= dhi_d;
			fuse_lo_q <= fuse_lo_d;
			fuse_hi_q <= fuse_hi_d;
			lock_q <= lock_d;
			page_ok_q <= page_ok_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
			dout_q <= dout_d;
			doe_n_q <= doe_n_d;
			ld_prev_q <= s_ld;
			pl_prev_q <= s_pl;
			wr_prev_q <= s_wr_n;
		end
	end

	// ==========================================================
	// array updates; arrays carry no reset, like the real cells
	always_ff @(posedge CLK_SYS)
	begin
		if (state_q == ST_READY && pl_rise)
			pbuf[alo_q[PAGE_AW-1:0]] <= {dhi_q, dlo_q};
		if (do_flash)
		begin
			for (int i = 0; i < 2**PAGE_AW; i++)
				flash_mem[{faddr[FLASH_AW-1:PAGE_AW], PAGE_AW'(i)}] <= pbuf[i];
		end
		if (do_ee)
		begin
			for (int i = 0; i < 2**EPAGE_AW; i++)
				ee_mem[{eaddr[EE_AW-1:EPAGE_AW], EPAGE_AW'(i)}] <=
					pbuf[{eaddr[PAGE_AW-1:EPAGE_AW], EPAGE_AW'(i)}][7:0];
		end
		if (do_erase)
		begin
			for (int i = 0; i < 2**FLASH_AW; i++)
				flash_mem[i] <= {BYTE_ERASED, BYTE_ERASED};
			for (int i = 0; i < 2**EE_AW; i++)
				ee_mem[i] <= BYTE_ERASED;
		end
	end

	assign PINS.ready_flag = ready_q;
	assign PINS.data_dev = dout_q;
	assign PINS.data_dev_oe_n = doe_n_q;
	assign FUSE_LO = fuse_lo_q;
	assign FUSE_HI = fuse_hi_q;
	assign LOCK_BITS = lock_q;
endmodule : ppp_dev

/* src/ppp_host.sv */
/*
 * programmer end: an APB slave whose control register launches one
 * timed pin sequence (load, page latch, program strobe or read).
 * assumes the device answers within the read window.
 */
`timescale 1ns/1ps
module ppp_host
	import ppp_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	ppp_if.host PINS
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_WAIT = 5'b00010,
		H_SETUP = 5'b00100,
		H_PULSE = 5'b01000,
		H_HOLD = 5'b10000
	} ppp_hstate_e;

	// ==========================================================
	// pins in from the device
	logic [8:0] sync_lvl;
	logic s_rdy;

	ppp_sync #(.W(9)) u_sync (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.pin({PINS.ready_flag, PINS.data}),
		.level(sync_lvl)
	);
	assign s_rdy = sync_lvl[8];

	ppp_hstate_e st_q, st_d;
	logic [13:0] ctrl_q, ctrl_d;
	logic [7:0] rdat_q, rdat_d, cnt_q, cnt_d;
	logic ld_q, ld_d, pl_q, pl_d, wr_n_q, wr_n_d, oe_n_q, oe_n_d;
	logic [1:0] ac_q, ac_d;
	logic bsl_q, bsl_d, bss_q, bss_d, hoe_n_q, hoe_n_d;
	logic pready_q, pready_d, perr_q, perr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [1:0] op;
	logic wr_fire, mapped;

	assign op = ctrl_q[CF_OP +: 2];
	assign mapped = (PADDR == REG_CTRL) || (PADDR == REG_STAT);
	assign wr_fire = PSEL && PENABLE && PWRITE && pready_q;

	// ==========================================================
	// APB: one wait state, then data and pready from flops
	always_comb
	begin
		pready_d = PSEL && PENABLE && !pready_q;
		perr_d = pready_d && !mapped;
		prdata_d = prdata_q;
		if (pready_d)
		begin
			prdata_d = 32'h00000000;
			if (PADDR == REG_CTRL)
				prdata_d[13:0] = ctrl_q;
			else if (PADDR == REG_STAT)
			begin
				prdata_d[SF_BUSY] = (st_q != H_IDLE);
				prdata_d[SF_READY] = s_rdy;
				prdata_d[SF_RDATA +: 8] = rdat_q;
			end
		end
	end

	// ==========================================================
	// pin sequencer
	always_comb
	begin
		st_d = st_q;
		ctrl_d = ctrl_q;
		rdat_d = rdat_q;
		cnt_d = cnt_q;
		ld_d = ld_q;
		pl_d = pl_q;
		wr_n_d = wr_n_q;
		oe_n_d = oe_n_q;
		ac_d = ac_q;
		bsl_d = bsl_q;
		bss_d = bss_q;
		hoe_n_d = hoe_n_q;
		case (st_q)
		H_IDLE:
		begin
			// a write while a sequence runs is dropped
			if (wr_fire && PADDR == REG_CTRL)
			begin
				ctrl_d = PWDATA[13:0];
				st_d = H_WAIT;
			end
		end
		H_WAIT:
		begin
			if (s_rdy)
			begin
				ac_d = (op == OP_LOAD) ? ctrl_q[CF_ACT +: 2] : ACT_IDLE;
				bsl_d = ctrl_q[CF_BSL];
				bss_d = ctrl_q[CF_BSS];
				hoe_n_d = (op != OP_LOAD);
				cnt_d = 8'(CYC_DVXH);
				st_d = H_SETUP;
			end
		end
		H_SETUP:
		begin
			cnt_d = cnt_q - 8'h01;
			if (cnt_q == 8'h01)
			begin
				ld_d = (op == OP_LOAD);
				pl_d = (op == OP_LATCH);
				wr_n_d = (op != OP_WRITE);
				oe_n_d = (op != OP_READ);
				cnt_d = (op == OP_READ) ? 8'(CYC_RD) : 8'(CYC_XHXL);
				st_d = H_PULSE;
			end
		end
		H_PULSE:
		begin
			cnt_d = cnt_q - 8'h01;
			if (cnt_q == 8'h01)
			begin
				if (op == OP_READ)
					rdat_d = sync_lvl[7:0];
				ld_d = 1'b0;
				pl_d = 1'b0;
				wr_n_d = 1'b1;
				oe_n_d = 1'b1;
				// after a program strobe, give the flag time to fall
				cnt_d = (op == OP_WRITE) ? 8'(CYC_WLRL) : 8'(CYC_XLDX);
				st_d = H_HOLD;
			end
		end
		H_HOLD:
		begin
			cnt_d = cnt_q - 8'h01;
			if (cnt_q == 8'h01)
			begin
				ac_d = ACT_IDLE;
				bsl_d = 1'b0;
				bss_d = 1'b0;
				hoe_n_d = 1'b1;
				st_d = H_IDLE;
			end
		end
		default:
			st_d = H_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			st_q <= H_IDLE;
			ctrl_q <= 14'h0000;
			rdat_q <= 8'h00;
			cnt_q <= 8'h00;
			ld_q <= 1'b0;
			pl_q <= 1'b0;
			wr_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			ac_q <= ACT_IDLE;
			bsl_q <= 1'b0;
			bss_q <= 1'b0;
			hoe_n_q <= 1'b1;
			pready_q <= 1'b0;
			perr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			rdat_q <= rdat_d;
			cnt_q <= cnt_d;
			ld_q <= ld_d;
			pl_q <= pl_d;
			wr_n_q <= wr_n_d;
			oe_n_q <= oe_n_d;
			ac_q <= ac_d;
			bsl_q <= bsl_d;
			bss_q <= bss_d;
			hoe_n_q <= hoe_n_d;
			pready_q <= pready_d;
			perr_q <= perr_d;
			prdata_q <= prdata_d;
		end
	end

	assign PREADY = pready_q;
	assign PSLVERR = perr_q;
	assign PRDATA = prdata_q;
	assign PINS.load_strobe = ld_q;
	assign PINS.page_latch_strobe = pl_q;
	assign PINS.prog_strobe_n = wr_n_q;
	assign PINS.out_en_n = oe_n_q;
	assign {PINS.action_code_hi, PINS.action_code_lo} = ac_q;
	assign PINS.byte_sel_low_high = bsl_q;
	assign PINS.byte_sel_second = bss_q;
	assign PINS.data_host = ctrl_q[CF_DATA +: 8];
	assign PINS.data_host_oe_n = hoe_n_q;
endmodule : ppp_host

/* verif/ppp_assertions.sv */
/*
 * pin-level checker for the programming port between host and device.
 * assumes one clock domain and instantiation beside the pin interface.
 */
`timescale 1ns/1ps
module ppp_assertions
	import ppp_pkg::*;
#(
	parameter int WRITE_CYC = CYC_WRITE,
	parameter int ERASE_CYC = CYC_ERASE
)(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic load_strobe,
	input wire logic action_code_hi,
	input wire logic action_code_lo,
	input wire logic byte_sel_low_high,
	input wire logic byte_sel_second,
	input wire logic page_latch_strobe,
	input wire logic prog_strobe_n,
	input wire logic out_en_n,
	input wire logic ready_flag,
	input wire logic [7:0] data_host,
	input wire logic data_host_oe_n,
	input wire logic data_dev_oe_n
);
	// ==========================================================
	// cycles since the program strobe fell
	// slack covers the pin synchroniser ahead of the device's timer
	localparam int SLACK = 16;
	logic [19:0] since_wr_q;
	logic [19:0] since_wr_d;
	logic wr_n_q;
	logic erase_q, erase_d;

	always_comb
	begin
		since_wr_d = since_wr_q;
		if (wr_n_q && !prog_strobe_n)
			since_wr_d = '0;
		else if (since_wr_q != 20'hFFFFF)
			since_wr_d = since_wr_q + 20'h1;
		erase_d = erase_q;
		if (load_strobe && action_code_hi && !action_code_lo)
			erase_d = data_host == CMD_ERASE;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			since_wr_q <= 20'hFFFFF;
			wr_n_q <= 1'b1;
			erase_q <= 1'b0;
		end
		else
		begin
			since_wr_q <= since_wr_d;
			wr_n_q <= prog_strobe_n;
			erase_q <= erase_d;
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);

	ready_fall_a: assert property (
		$fell(ready_flag) |-> since_wr_q <= CYC_WLRL)
		else $error("ready flag fell late or without a program strobe");
	write_time_a: assert property (
		$rose(ready_flag) && !erase_q
		|-> since_wr_q >= WRITE_CYC && since_wr_q <= WRITE_CYC + SLACK)
		else $error("write busy time out of range");
	erase_time_a: assert property (
		$rose(ready_flag) && erase_q
		|-> since_wr_q >= ERASE_CYC && since_wr_q <= ERASE_CYC + SLACK)
		else $error("erase busy time out of range");
	busy_hold_a: assert property (
		$fell(ready_flag) |-> !ready_flag[*8])
		else $error("ready flag returned too soon");
	strobe_ready_a: assert property (
		$rose(load_strobe) || $rose(page_latch_strobe) || $fell(prog_strobe_n)
		|-> ready_flag)
		else $error("strobe given while device busy");
	load_pulse_a: assert property (
		$rose(load_strobe) |-> (load_strobe && !data_host_oe_n
		&& $stable({action_code_hi, action_code_lo, byte_sel_low_high,
		data_host}))[*6] ##1 !load_strobe)
		else $error("load pulse or its qualifiers unstable");
	latch_pulse_a: assert property (
		$rose(page_latch_strobe) |-> (page_latch_strobe
		&& $stable(byte_sel_low_high))[*6] ##1 !page_latch_strobe)
		else $error("page latch pulse malformed");
	prog_pulse_a: assert property (
		$fell(prog_strobe_n) |-> (!prog_strobe_n
		&& $stable({byte_sel_low_high, byte_sel_second}))[*6] ##1 prog_strobe_n)
		else $error("program pulse or selects unstable");
	read_window_a: assert property (
		$fell(out_en_n) |-> !out_en_n[*8] ##[1:20] out_en_n)
		else $error("output enable window malformed");
	dev_drive_a: assert property (
		$fell(data_dev_oe_n) |-> !out_en_n)
		else $error("device drives bus without output enable");
	dev_release_a: assert property (
		$rose(out_en_n) |-> ##[1:10] data_dev_oe_n)
		else $error("device kept bus after output enable rose");
	no_fight_a: assert property (
		!data_host_oe_n |-> out_en_n)
		else $error("host drives bus while reading");
endmodule : ppp_assertions

/* verif/tb_top.sv */
/*
 * testbench: APB writes to the host launch pin sequences into the device.
 * assumes the short busy counts set below on the device instance.
 */
`timescale 1ns/1ps
module tb_top
	import ppp_pkg::*;
;
	localparam int WR_CYC = 20;
	localparam int ER_CYC = 40;
	// identification and calibration values are arbitrary
	localparam logic [23:0] IDS = 24'h636261;
	localparam logic [7:0] CAL = 8'h44;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] fuse_lo;
	logic [7:0] fuse_hi;
	logic [7:0] lock_bits;
	logic [7:0] fw_a [2] = '{8'h00, 8'h3F};
	logic [15:0] fw_d [2] = '{16'hA55A, 16'h0FF0};
	int n_fail = 0;
	int tests_run = 0;

	always #12.5 clk_sys = ~clk_sys;

	ppp_if bus();
	ppp_dev #(.WRITE_CYC(WR_CYC), .ERASE_CYC(ER_CYC), .ID0(IDS[7:0]),
		.ID1(IDS[15:8]), .ID2(IDS[23:16]), .CAL_BYTE(CAL)) ppp_dev_i (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .PINS(bus), .FUSE_LO(fuse_lo),
		.FUSE_HI(fuse_hi), .LOCK_BITS(lock_bits));
	ppp_host ppp_host_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PINS(bus));
	ppp_assertions #(.WRITE_CYC(WR_CYC), .ERASE_CYC(ER_CYC)) ppp_assertions_i (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .load_strobe(bus.load_strobe),
		.action_code_hi(bus.action_code_hi),
		.action_code_lo(bus.action_code_lo),
		.byte_sel_low_high(bus.byte_sel_low_high),
		.byte_sel_second(bus.byte_sel_second),
		.page_latch_strobe(bus.page_latch_strobe),
		.prog_strobe_n(bus.prog_strobe_n), .out_en_n(bus.out_en_n),
		.ready_flag(bus.ready_flag), .data_host(bus.data_host),
		.data_host_oe_n(bus.data_host_oe_n),
		.data_dev_oe_n(bus.data_dev_oe_n));

	// ==========================================================
	// reporting
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// ==========================================================
	// bus and pin-sequence tasks, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	// a new order is refused while a sequence runs, so poll it out
	task automatic ctl(input logic [1:0] op, input logic [1:0] act,
		input logic lh, input logic sb, input logic [7:0] d,
		output logic [7:0] rb);
		logic [31:0] r;
		logic e;
		apb(1'b1, REG_CTRL, {18'h0, op, sb, lh, act, d}, r, e);
		do
			apb(1'b0, REG_STAT, 32'h0, r, e);
		while (r[SF_BUSY] !== 1'b0);
		rb = r[SF_RDATA +: 8];
	endtask : ctl

	task automatic ld(input logic [1:0] act, input logic lh,
		input logic [7:0] d);
		logic [7:0] b;
		ctl(OP_LOAD, act, lh, 1'b0, d, b);
	endtask : ld

	task automatic cmd(input logic [7:0] c);
		ld(ACT_CMD, 1'b0, c);
	endtask : cmd

	task automatic latch(input logic lh);
		logic [7:0] b;
		ctl(OP_LATCH, ACT_IDLE, lh, 1'b0, 8'h00, b);
	endtask : latch

	task automatic wr(input logic lh, input logic sb);
		logic [7:0] b;
		ctl(OP_WRITE, ACT_IDLE, lh, sb, 8'h00, b);
	endtask : wr

	task automatic rchk(input logic lh, input logic sb,
		input logic [7:0] exp, input string nm);
		logic [7:0] b;
		ctl(OP_READ, ACT_IDLE, lh, sb, 8'h00, b);
		chk(nm, {24'h0, exp}, {24'h0, b});
	endtask : rchk

	// ==========================================================
	// watchdog: about 100 sequences of under 200 cycles each
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		wrap_up();
	end

	initial
	begin
		logic [31:0] r;
		logic e;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk_sys);
		apb(1'b0, REG_STAT, 32'h0, r, e);
		chk("idle status", 32'h2, {30'h0, r[1:0]});
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		chk("lock reset", 32'hFF, {24'h0, lock_bits});
		cmd(CMD_ERASE);
		wr(1'b0, 1'b0);
		cmd(CMD_WFLASH);
		ld(ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			ld(ACT_ADDR, 1'b0, fw_a[i]);
			ld(ACT_DATA, 1'b0, fw_d[i][7:0]);
			ld(ACT_DATA, 1'b1, fw_d[i][15:8]);
			latch(1'b1);
		end
		wr(1'b0, 1'b0);
		cmd(CMD_NOP);
		// a latched word dropped by the no-op must never reach the array
		cmd(CMD_WFLASH);
		ld(ACT_ADDR, 1'b0, 8'h80);
		ld(ACT_DATA, 1'b0, 8'h12);
		latch(1'b1);
		cmd(CMD_NOP);
		cmd(CMD_WFLASH);
		ld(ACT_ADDR, 1'b0, 8'h80);
		wr(1'b0, 1'b0);
		cmd(CMD_NOP);
		cmd(CMD_RFLASH);
		ld(ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			ld(ACT_ADDR, 1'b0, fw_a[i]);
			rchk(1'b0, 1'b0, fw_d[i][7:0], "flash low byte");
			rchk(1'b1, 1'b0, fw_d[i][15:8], "flash high byte");
		end
		ld(ACT_ADDR, 1'b0, 8'h80);
		rchk(1'b0, 1'b0, BYTE_ERASED, "dropped page");
		cmd(CMD_WEE);
		ld(ACT_ADDR, 1'b1, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			ld(ACT_ADDR, 1'b0, 8'(8'h04 + i));
			ld(ACT_DATA, 1'b0, 8'(8'hC0 + i));
			latch(1'b1);
		end
		wr(1'b0, 1'b0);
		cmd(CMD_NOP);
		cmd(CMD_REE);
		ld(ACT_ADDR, 1'b1, 8'h01);
		for (int i = 0; i < 5; i++)
		begin
			ld(ACT_ADDR, 1'b0, 8'(8'h04 + i));
			rchk(1'b0, 1'b0, (i < 4) ? 8'(8'hC0 + i) : BYTE_ERASED,
				"eeprom byte");
		end
		cmd(CMD_WFUSE);
		ld(ACT_DATA, 1'b0, 8'hA6);
		wr(1'b0, 1'b0);
		ld(ACT_DATA, 1'b0, 8'h5C);
		wr(1'b1, 1'b0);
		cmd(CMD_WLOCK);
		ld(ACT_DATA, 1'b0, 8'hF0);
		wr(1'b0, 1'b0);
		ld(ACT_DATA, 1'b0, 8'h0F);
		wr(1'b0, 1'b0);
		cmd(CMD_RFUSE);
		rchk(1'b0, 1'b0, 8'hA6, "fuse low");
		rchk(1'b1, 1'b1, 8'h5C, "fuse high");
		rchk(1'b1, 1'b0, 8'h00, "lock bits");
		chk("fuse high pins", 32'h5C, {24'h0, fuse_hi});
		cmd(CMD_RSIG);
		for (int i = 0; i < 3; i++)
		begin
			ld(ACT_ADDR, 1'b0, 8'(i));
			rchk(1'b0, 1'b0, IDS[8 * i +: 8], "id byte");
		end
		ld(ACT_ADDR, 1'b0, 8'h00);
		rchk(1'b1, 1'b0, CAL, "calibration");
		cmd(CMD_ERASE);
		wr(1'b0, 1'b0);
		cmd(CMD_RFLASH);
		ld(ACT_ADDR, 1'b0, 8'h3F);
		rchk(1'b1, 1'b0, BYTE_ERASED, "erased flash");
		chk("lock after erase", 32'hFF, {24'h0, lock_bits});
		chk("fuse kept", 32'hA6, {24'h0, fuse_lo});
		wrap_up();
	end
endmodule : tb_top
